// file: src/mdfr_device.sv
// Overview of operation
// - Each register holds one 16-bit word
// - Host stays inside sixteen-byte window
// - Reserved words written zero, read undefined
// - Immediate registers apply unless value abnormal
// - Config registers apply on commit only
// - Bad commit raises error, stays setting
// - Bits 15,14 forbid fault/power indicators
// - Bit 9 filter on, bit 8 smooth on
// - Bits 3,2 clear/reset, bit 1 excite
// - Clear and reset act on rising edge
// - Host writes zero before repeating one
// - Error clear resets counter and flag
// - Reserved control bits read undefined, written zero
// - Run ratio 1..1000, resets 1000
// - Run current equals rated times ratio/1000
// - Hold ratio 1..500, resets 500
// - Host never sets hold above half
// - Hold ratio reference chosen by config bit
// - Config writes in operation do nothing
// - Config bit 3 selects operating reference
`timescale 1ns/10ps
module mdfr_device
   import mdfr_pkg::*;
#(
   parameter logic [11:0] RATED_MA [6] = '{12'd500, 12'd900, 12'd1300, 12'd1700, 12'd2200, 12'd2800}
)(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   mdfr_link_if.dev         link,
   input  wire logic        comm_error_event,
   output logic             fault_indicator_off,
   output logic             power_indicator_off,
   output logic             cmd_filter_on,
   output logic             smooth_drive_on,
   output logic             excite_on,
   output logic             comm_error_clear,
   output logic             fault_reset,
   output logic             comm_error_flag,
   output logic [7:0]       comm_error_count,
   output logic             cmd_exec_alarm,
   output logic             operating,
   output logic [11:0]      run_current_ma,
   output logic [11:0]      hold_current_ma,
   output logic [15:0]      step_resolution,
   output logic             two_pulse_mode
);
   // ****************************************
   // Storage
   // ****************************************
   mdfr_state_e state;
   logic [15:0] host_control_bits;
   logic [15:0] run_current_ratio;
   logic [15:0] hold_current_ratio;
   logic [15:0] cfg_written;
   logic [15:0] res_written;
   logic [15:0] size_written;
   logic [15:0] driver_config;
   logic [15:0] motor_size_select;

   // ****************************************
   // Decode
   // ****************************************
   wire         wr_ctrl    = link.wr_req && (link.addr == ADDR_HOST_CTRL);
   wire         wr_run     = link.wr_req && (link.addr == ADDR_RUN_RATIO);
   wire         wr_hold    = link.wr_req && (link.addr == ADDR_HOLD_RATIO);
   wire         in_setting = (state == MDFR_SETTING);
   // Writes to staged words during operation are dropped silently
   wire         wr_cfg     = link.wr_req && in_setting && (link.addr == ADDR_DRV_CFG);
   wire         wr_res     = link.wr_req && in_setting && (link.addr == ADDR_STEP_RES);
   wire         wr_size    = link.wr_req && in_setting && (link.addr == ADDR_MOTOR_SIZE);
   wire         run_ok     = mdfr_ratio_ok(link.wdata, RUN_RATIO_MAX);
   wire         hold_ok    = mdfr_ratio_ok(link.wdata, HOLD_RATIO_MAX);
   wire         commit_ok  = cfg_written[BIT_PULSE_SRC] && mdfr_size_ok(size_written)
                             && (res_written >= STEP_RES_MIN) && (res_written <= STEP_RES_MAX);
   wire         do_commit  = link.commit_req && in_setting && commit_ok;
   wire         bad_commit = link.commit_req && in_setting && !commit_ok;
   wire [15:0]  ctrl_next  = link.wdata & CTRL_MASK;
   // Rising edges only; a held one does nothing further
   wire         clr_rise   = wr_ctrl && ctrl_next[BIT_ERR_CLEAR] && !host_control_bits[BIT_ERR_CLEAR];
   wire         rst_rise   = wr_ctrl && ctrl_next[BIT_FAULT_RESET] && !host_control_bits[BIT_FAULT_RESET];

   // Reserved words and bits read as zero
   logic [15:0] rd_mux;
   always_comb begin
      case (link.addr)
         ADDR_HOST_CTRL:  rd_mux = host_control_bits;
         ADDR_RUN_RATIO:  rd_mux = run_current_ratio;
         ADDR_HOLD_RATIO: rd_mux = hold_current_ratio;
         ADDR_DRV_CFG:    rd_mux = cfg_written;
         ADDR_STEP_RES:   rd_mux = res_written;
         ADDR_MOTOR_SIZE: rd_mux = size_written;
         default:         rd_mux = 16'h0000;
      endcase
   end

   // ****************************************
   // Current arithmetic
   // ****************************************
   wire [2:0]   size_idx   = motor_size_select[2:0];
   wire [11:0]  rated_ma   = RATED_MA[size_idx];
   wire [21:0]  run_prod   = rated_ma * run_current_ratio[9:0];
   wire [11:0]  next_run   = 12'(run_prod / 22'(RATIO_FULL));
   // Reference for the hold ratio follows the committed config bit
   wire [11:0]  hold_base  = driver_config[BIT_HOLD_REF] ? next_run : rated_ma;
   wire [21:0]  hold_prod  = hold_base * hold_current_ratio[9:0];
   wire [11:0]  next_hold  = 12'(hold_prod / 22'(RATIO_FULL));

   // ****************************************
   // Host-visible registers
   // ****************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         host_control_bits  <= RST_HOST_CTRL;
         run_current_ratio  <= RST_RUN_RATIO;
         hold_current_ratio <= RST_HOLD_RATIO;
         cfg_written        <= RST_DRV_CFG;
         res_written        <= RST_STEP_RES;
         size_written       <= RST_MOTOR_SIZE;
      end else begin
         if (wr_ctrl) begin
            host_control_bits <= ctrl_next;
         end
         if (wr_run && run_ok) begin
            run_current_ratio <= link.wdata;
         end
         if (wr_hold && hold_ok) begin
            hold_current_ratio <= link.wdata;
         end
         if (wr_cfg) begin
            cfg_written <= link.wdata & CFG_MASK;
         end
         if (wr_res) begin
            res_written <= link.wdata;
         end
         if (wr_size) begin
            size_written <= link.wdata;
         end
      end
   end

   // ****************************************
   // Internal state and committed values
   // ****************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state             <= MDFR_SETTING;
         driver_config     <= RST_DRV_CFG;
         step_resolution   <= RST_STEP_RES;
         motor_size_select <= RST_MOTOR_SIZE;
      end else begin
         case (state)
            MDFR_SETTING: begin
               if (do_commit) begin
                  driver_config     <= cfg_written;
                  step_resolution   <= res_written;
                  motor_size_select <= size_written;
                  state             <= MDFR_OPERATION;
               end
            end
            MDFR_OPERATION: begin
               if (link.release_req) begin
                  state <= MDFR_SETTING;
               end
            end
            default: state <= MDFR_SETTING;
         endcase
      end
   end

   // ****************************************
   // Errors, alarm and action pulses
   // ****************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         comm_error_flag  <= 1'b0;
         comm_error_count <= 8'h00;
         cmd_exec_alarm   <= 1'b0;
         comm_error_clear <= 1'b0;
         fault_reset      <= 1'b0;
      end else begin
         comm_error_clear <= clr_rise;
         fault_reset      <= rst_rise;
         // A new error in the clearing cycle still counts
         if (comm_error_event) begin
            comm_error_flag <= 1'b1;
            if (clr_rise) begin
               comm_error_count <= 8'h01;
            end else if (comm_error_count != ERR_COUNT_MAX) begin
               comm_error_count <= comm_error_count + 8'h01;
            end
         end else if (clr_rise) begin
            comm_error_flag  <= 1'b0;
            comm_error_count <= 8'h00;
         end
         if (bad_commit) begin
            cmd_exec_alarm <= 1'b1;
         end else if (rst_rise) begin
            cmd_exec_alarm <= 1'b0;
         end
      end
   end

   // ****************************************
   // Answers and registered outputs
   // ****************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         link.rdata          <= 16'h0000;
         link.ack            <= 1'b0;
         link.cmd_ack        <= 1'b0;
         link.cmd_err        <= 1'b0;
         fault_indicator_off <= 1'b0;
         power_indicator_off <= 1'b0;
         cmd_filter_on       <= 1'b0;
         smooth_drive_on     <= 1'b1;
         excite_on           <= 1'b0;
         operating           <= 1'b0;
         two_pulse_mode      <= 1'b0;
         run_current_ma      <= 12'h000;
         hold_current_ma     <= 12'h000;
      end else begin
         link.rdata          <= link.rd_req ? rd_mux : 16'h0000;
         link.ack            <= link.rd_req || link.wr_req;
         link.cmd_ack        <= link.commit_req || link.release_req;
         // Commit in operation is acknowledged but changes nothing
         link.cmd_err        <= bad_commit;
         fault_indicator_off <= host_control_bits[BIT_FAULT_LED];
         power_indicator_off <= host_control_bits[BIT_POWER_LED];
         cmd_filter_on       <= host_control_bits[BIT_FILTER];
         smooth_drive_on     <= host_control_bits[BIT_SMOOTH];
         // No excitation until committed
         excite_on           <= host_control_bits[BIT_EXCITE] && !in_setting;
         operating           <= !in_setting;
         two_pulse_mode      <= driver_config[BIT_PULSE_MODE];
         run_current_ma      <= next_run;
         hold_current_ma     <= next_hold;
      end
   end
endmodule

// file: src/mdfr_pkg.sv
package mdfr_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [3:0]  ADDR_RSVD_A      = 4'h0;
   localparam logic [3:0]  ADDR_HOST_CTRL   = 4'h2;
   localparam logic [3:0]  ADDR_RUN_RATIO   = 4'h4;
   localparam logic [3:0]  ADDR_HOLD_RATIO  = 4'h6;
   localparam logic [3:0]  ADDR_RSVD_B      = 4'h8;
   localparam logic [3:0]  ADDR_DRV_CFG     = 4'ha;
   localparam logic [3:0]  ADDR_STEP_RES    = 4'hc;
   localparam logic [3:0]  ADDR_MOTOR_SIZE  = 4'he;
   // ****************************************
   // Field positions and masks
   // ****************************************
   localparam int          BIT_FAULT_LED    = 15;
   localparam int          BIT_POWER_LED    = 14;
   localparam int          BIT_FILTER       = 9;
   localparam int          BIT_SMOOTH       = 8;
   localparam int          BIT_ERR_CLEAR    = 3;
   localparam int          BIT_FAULT_RESET  = 2;
   localparam int          BIT_EXCITE       = 1;
   localparam int          BIT_PULSE_SRC    = 14;
   localparam int          BIT_HOLD_REF     = 3;
   localparam int          BIT_PULSE_MODE   = 6;
   localparam logic [15:0] CTRL_MASK        = 16'hc30e;
   localparam logic [15:0] CFG_MASK         = 16'h7e48;
   // ****************************************
   // Reset values and legal ranges
   // ****************************************
   localparam logic [15:0] RST_HOST_CTRL    = 16'h0100;
   localparam logic [15:0] RST_RUN_RATIO    = 16'h03e8;
   localparam logic [15:0] RST_HOLD_RATIO   = 16'h01f4;
   localparam logic [15:0] RST_DRV_CFG      = 16'h7800;
   localparam logic [15:0] RST_STEP_RES     = 16'h000a;
   localparam logic [15:0] RST_MOTOR_SIZE   = 16'hff00;
   localparam logic [15:0] RATIO_FULL       = 16'h03e8;
   localparam logic [15:0] RUN_RATIO_MAX    = 16'h03e8;
   localparam logic [15:0] HOLD_RATIO_MAX   = 16'h01f4;
   localparam logic [15:0] STEP_RES_MIN     = 16'h0004;
   localparam logic [15:0] STEP_RES_MAX     = 16'h09c4;
   localparam logic [7:0]  SIZE_CODE_MAX    = 8'h05;
   localparam logic [7:0]  ERR_COUNT_MAX    = 8'hff;

   typedef enum logic [0:0] {
      MDFR_SETTING   = 1'b0,
      MDFR_OPERATION = 1'b1
   } mdfr_state_e;

   // Ratio in 0.1 percent steps, 1 up to max
   function automatic logic mdfr_ratio_ok(input logic [15:0] v, input logic [15:0] max);
      mdfr_ratio_ok = (v != 16'h0000) && (v <= max);
   endfunction

   // Size codes pair a high byte that is the complement of the low byte
   function automatic logic mdfr_size_ok(input logic [15:0] v);
      mdfr_size_ok = (v[15:8] == ~v[7:0]) && (v[7:0] <= SIZE_CODE_MAX);
   endfunction
endpackage

// file: src/mdfr_link_if.sv
`timescale 1ns/10ps
interface mdfr_link_if;
   logic        wr_req;
   logic        rd_req;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        ack;
   logic        commit_req;
   logic        release_req;
   logic        cmd_ack;
   logic        cmd_err;

   modport dev  (input wr_req, rd_req, addr, wdata, commit_req, release_req,
                 output rdata, ack, cmd_ack, cmd_err);
   modport host (output wr_req, rd_req, addr, wdata, commit_req, release_req,
                 input rdata, ack, cmd_ack, cmd_err);
endinterface

// file: src/mdfr_host.sv
`timescale 1ns/10ps
module mdfr_host
   import mdfr_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   mdfr_link_if.host        link,
   input  wire logic        user_req,
   input  wire logic        user_wr,
   input  wire logic [3:0]  user_addr,
   input  wire logic [15:0] user_wdata,
   input  wire logic        user_commit,
   input  wire logic        user_release,
   output logic             user_busy,
   output logic             user_done,
   output logic [15:0]      user_rdata,
   output logic             user_cmd_err
);
   typedef enum logic [1:0] {
      MDFR_H_IDLE = 2'b00,
      MDFR_H_ZERO = 2'b01,
      MDFR_H_SEND = 2'b10,
      MDFR_H_WAIT = 2'b11
   } mdfr_hstate_e;

   mdfr_hstate_e hstate;
   logic [15:0]  last_ctrl;
   logic [15:0]  held_data;
   logic [3:0]   held_addr;
   logic         held_wr;

   // ****************************************
   // Request shaping
   // ****************************************
   // Word aligned; a 4-bit address cannot leave the window
   wire [3:0]  al_addr  = {user_addr[3:1], 1'b0};
   wire        is_rsvd  = (al_addr == ADDR_RSVD_A) || (al_addr == ADDR_RSVD_B);
   wire        is_ctrl  = (al_addr == ADDR_HOST_CTRL);
   wire        is_hold  = (al_addr == ADDR_HOLD_RATIO);
   wire [15:0] clamp    = (is_hold && user_wdata > HOLD_RATIO_MAX) ? HOLD_RATIO_MAX : user_wdata;
   wire [15:0] shaped   = is_rsvd ? 16'h0000 :
                          is_ctrl ? (clamp & CTRL_MASK) :
                          (al_addr == ADDR_DRV_CFG) ? (clamp & CFG_MASK) : clamp;
   wire [15:0] pulse_b  = 16'((1 << BIT_ERR_CLEAR) | (1 << BIT_FAULT_RESET));
   // A repeated one on clear/reset needs a zero first
   wire        need_zro = user_wr && is_ctrl && |(shaped & last_ctrl & pulse_b);
   wire        start    = user_req && hstate == MDFR_H_IDLE;
   wire        cmd_go   = (user_commit || user_release) && hstate == MDFR_H_IDLE && !user_req;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         hstate           <= MDFR_H_IDLE;
         last_ctrl        <= RST_HOST_CTRL;
         held_data        <= 16'h0000;
         held_addr        <= 4'h0;
         held_wr          <= 1'b0;
         link.wr_req      <= 1'b0;
         link.rd_req      <= 1'b0;
         link.addr        <= 4'h0;
         link.wdata       <= 16'h0000;
         link.commit_req  <= 1'b0;
         link.release_req <= 1'b0;
         user_busy        <= 1'b0;
         user_done        <= 1'b0;
         user_rdata       <= 16'h0000;
         user_cmd_err     <= 1'b0;
      end else begin
         link.wr_req      <= 1'b0;
         link.rd_req      <= 1'b0;
         link.commit_req  <= cmd_go && user_commit;
         link.release_req <= cmd_go && !user_commit;
         user_done        <= 1'b0;
         if (link.cmd_ack) begin
            user_cmd_err <= link.cmd_err;
         end
         case (hstate)
            MDFR_H_IDLE: begin
               if (start) begin
                  held_data  <= shaped;
                  held_addr  <= al_addr;
                  held_wr    <= user_wr;
                  user_busy  <= 1'b1;
                  link.addr  <= al_addr;
                  if (need_zro) begin
                     link.wr_req <= 1'b1;
                     link.wdata  <= shaped & ~pulse_b;
                     hstate      <= MDFR_H_ZERO;
                  end else begin
                     hstate <= MDFR_H_SEND;
                  end
               end
            end
            MDFR_H_ZERO: begin
               hstate <= MDFR_H_SEND;
            end
            MDFR_H_SEND: begin
               link.wr_req <= held_wr;
               link.rd_req <= !held_wr;
               link.addr   <= held_addr;
               link.wdata  <= held_wr ? held_data : 16'h0000;
               if (held_wr && held_addr == ADDR_HOST_CTRL) begin
                  last_ctrl <= held_data;
               end
               hstate <= MDFR_H_WAIT;
            end
            MDFR_H_WAIT: begin
               if (link.ack) begin
                  user_rdata <= link.rdata;
                  user_done  <= 1'b1;
                  user_busy  <= 1'b0;
                  hstate     <= MDFR_H_IDLE;
               end
            end
            default: hstate <= MDFR_H_IDLE;
         endcase
      end
   end
endmodule

// file: verification/mdfr_assertions.sv
`timescale 1ns/10ps
module mdfr_assertions
   import mdfr_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        wr_req,
   input wire logic        rd_req,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        ack,
   input wire logic        commit_req,
   input wire logic        release_req,
   input wire logic        cmd_ack,
   input wire logic        cmd_err
);
   // ****************************************
   // Decodes of the request side
   // ****************************************
   wire logic req_any  = wr_req || rd_req;
   wire logic cmd_any  = commit_req || release_req;
   wire logic rd_rsvd  = rd_req && (addr == ADDR_RSVD_A || addr == ADDR_RSVD_B);
   wire logic rd_ctrl  = rd_req && (addr == ADDR_HOST_CTRL);
   wire logic rd_run   = rd_req && (addr == ADDR_RUN_RATIO);
   wire logic rd_hold  = rd_req && (addr == ADDR_HOLD_RATIO);

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // ****************************************
   // Link properties
   // ****************************************
   AST_ACK_AFTER_REQ: assert property (req_any |=> ack)
      else $error("ack missing one cycle after a register request");
   AST_NO_STRAY_ACK: assert property (ack |-> $past(req_any))
      else $error("ack without a preceding register request");
   AST_IDLE_RDATA_ZERO: assert property (!$past(rd_req) |-> rdata == 16'h0000)
      else $error("read data driven outside a read answer");
   AST_RSVD_READ_ZERO: assert property (rd_rsvd |=> ack && rdata == 16'h0000)
      else $error("reserved word read back nonzero");
   AST_CTRL_RSVD_BITS: assert property (rd_ctrl |=> (rdata & ~CTRL_MASK) == 16'h0000)
      else $error("reserved control bits read back set");
   AST_RUN_RANGE: assert property (rd_run |=> rdata != 16'h0000 && rdata <= RUN_RATIO_MAX)
      else $error("run ratio holds a value outside its range");
   AST_HOLD_RANGE: assert property (rd_hold |=> rdata != 16'h0000 && rdata <= HOLD_RATIO_MAX)
      else $error("hold ratio holds a value outside its range");
   AST_CMD_ANSWER: assert property (cmd_any |=> cmd_ack)
      else $error("command not answered one cycle later");
   AST_ERR_WITH_ACK: assert property (cmd_err |-> cmd_ack && $past(commit_req))
      else $error("command error outside a commit answer");

   COV_WRITE: cover property (wr_req ##1 ack);
   COV_BAD_COMMIT: cover property (commit_req ##1 cmd_err);
   COV_GOOD_COMMIT: cover property (commit_req ##1 (cmd_ack && !cmd_err));
endmodule

// file: verification/test_motor_driver_function_registers.sv
`timescale 1ns/10ps
module test_motor_driver_function_registers
   import mdfr_pkg::*;
;
   // Multiples of 400 keep every expected current exact
   localparam logic [11:0] RATED [6] = '{12'd400, 12'd800, 12'd1200, 12'd1600, 12'd2000, 12'd2400};
   logic        mclk, rst_b, comm_error_event, user_req, user_wr, user_commit, user_release;
   logic [3:0]  user_addr;
   logic [15:0] user_wdata, user_rdata, rd, v, s, run_m, hold_m;
   logic        user_busy, user_done, user_cmd_err, fault_indicator_off, power_indicator_off;
   logic        cmd_filter_on, smooth_drive_on, excite_on, comm_error_clear, fault_reset;
   logic        comm_error_flag, cmd_exec_alarm, operating, two_pulse_mode;
   logic [7:0]  comm_error_count;
   logic [11:0] run_current_ma, hold_current_ma;
   logic [15:0] step_resolution;
   logic [15:0] rst_val [8] = '{16'h0000, 16'h0100, 16'h03e8, 16'h01f4, 16'h0000, 16'h7800, 16'h000a, 16'hff00};
   logic [15:0] corner [6] = '{16'h0000, 16'h0001, 16'h01f4, 16'h01f5, 16'h03e8, 16'h03e9};
   int          num_errors, num_checks, cycles, n_clr, n_rst, c0, r0;

   mdfr_link_if lnk();
   mdfr_device #(.RATED_MA(RATED)) mdfr_device_i (
      .mclk(mclk), .rst_b(rst_b), .link(lnk.dev), .comm_error_event(comm_error_event),
      .fault_indicator_off(fault_indicator_off), .power_indicator_off(power_indicator_off),
      .cmd_filter_on(cmd_filter_on), .smooth_drive_on(smooth_drive_on), .excite_on(excite_on),
      .comm_error_clear(comm_error_clear), .fault_reset(fault_reset), .comm_error_flag(comm_error_flag),
      .comm_error_count(comm_error_count), .cmd_exec_alarm(cmd_exec_alarm), .operating(operating),
      .run_current_ma(run_current_ma), .hold_current_ma(hold_current_ma),
      .step_resolution(step_resolution), .two_pulse_mode(two_pulse_mode));
   mdfr_host mdfr_host_i (
      .mclk(mclk), .rst_b(rst_b), .link(lnk.host), .user_req(user_req), .user_wr(user_wr),
      .user_addr(user_addr), .user_wdata(user_wdata), .user_commit(user_commit),
      .user_release(user_release), .user_busy(user_busy), .user_done(user_done),
      .user_rdata(user_rdata), .user_cmd_err(user_cmd_err));
   mdfr_assertions mdfr_assertions_i (
      .mclk(mclk), .rst_b(rst_b), .wr_req(lnk.wr_req), .rd_req(lnk.rd_req), .addr(lnk.addr),
      .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack), .commit_req(lnk.commit_req),
      .release_req(lnk.release_req), .cmd_ack(lnk.cmd_ack), .cmd_err(lnk.cmd_err));

   // ****************************************
   // Clock, pulse counters, hang guard
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      n_clr <= n_clr + int'(comm_error_clear === 1'b1);
      n_rst <= n_rst + int'(fault_reset === 1'b1);
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end

   // ****************************************
   // Bench helpers
   // ****************************************
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   function automatic logic [15:0] scale(input logic [15:0] base, input logic [15:0] ratio);
      return 16'((32'(base) * 32'(ratio)) / 1000);
   endfunction

   task automatic close_out();
      $display("Checks made: %0d, mismatches: %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask

   // One host user transfer; done is bounded so a lost answer cannot hang the run
   task automatic access(input logic wr, input logic [3:0] a, input logic [15:0] d);
      int n;
      @(posedge mclk);
      user_req <= 1'b1;
      user_wr <= wr;
      user_addr <= a;
      user_wdata <= d;
      @(posedge mclk);
      user_req <= 1'b0;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (user_done !== 1'b1 && n < 20);
      if (n >= 20) num_errors++;
      rd = user_rdata;
   endtask

   task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
      access(1'b0, a, 16'h0000);
      chk(rd, exp);
   endtask

   task automatic cmd(input logic commit);
      int n;
      @(posedge mclk);
      user_commit <= commit;
      user_release <= !commit;
      @(posedge mclk);
      user_commit <= 1'b0;
      user_release <= 1'b0;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (lnk.cmd_ack !== 1'b1 && n < 20);
      if (n >= 20) num_errors++;
      settle();
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {rst_b, comm_error_event, user_req, user_wr, user_commit, user_release} = '0;
      user_addr = 4'h0;
      user_wdata = 16'h0000;
      {num_errors, num_checks, cycles, n_clr, n_rst} = '0;
      s = 16'h003f;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      settle();
      for (int i = 0; i < 8; i++) rchk(4'(2 * i), rst_val[i]);
      chk(smooth_drive_on, 1'b1);
      chk({fault_indicator_off, power_indicator_off, cmd_filter_on, excite_on}, 4'h0);
      chk(run_current_ma, 12'd400);
      chk(hold_current_ma, 12'd200);
      run_m = RST_RUN_RATIO;
      hold_m = RST_HOLD_RATIO;
      // Corners first, then random values that cross both limits
      for (int i = 0; i < 14; i++) begin
         s = lfsr(s);
         v = (i < 6) ? corner[i] : {5'h00, s[10:0]};
         access(1'b1, ADDR_RUN_RATIO, v);
         if (v != 16'h0000 && v <= 16'h03e8) run_m = v;
         rchk(ADDR_RUN_RATIO, run_m);
         access(1'b1, ADDR_HOLD_RATIO, v);
         if (v != 16'h0000) hold_m = (v > 16'h01f4) ? 16'h01f4 : v;
         rchk(ADDR_HOLD_RATIO, hold_m);
      end
      chk(user_busy, 1'b0);
      access(1'b1, ADDR_RUN_RATIO, 16'h01f4);
      access(1'b1, ADDR_HOLD_RATIO, 16'h00fa);
      settle();
      chk(run_current_ma, scale(16'd400, 16'h01f4));
      chk(hold_current_ma, scale(16'd400, 16'h00fa));
      c0 = n_clr;
      r0 = n_rst;
      access(1'b1, ADDR_HOST_CTRL, 16'hffff);
      settle();
      rchk(ADDR_HOST_CTRL, 16'hc30e);
      chk({fault_indicator_off, power_indicator_off, cmd_filter_on, smooth_drive_on}, 4'hf);
      chk(excite_on, 1'b0);
      chk(16'(n_clr - c0), 16'h0001);
      chk(16'(n_rst - r0), 16'h0001);
      repeat (3) begin
         @(posedge mclk);
         comm_error_event <= 1'b1;
         @(posedge mclk);
         comm_error_event <= 1'b0;
      end
      settle();
      chk({comm_error_flag, comm_error_count}, 16'h0103);
      access(1'b1, ADDR_HOST_CTRL, 16'hc30e);
      settle();
      chk({comm_error_flag, comm_error_count}, 16'h0000);
      chk(16'(n_clr - c0), 16'h0002);
      rchk(ADDR_HOST_CTRL, 16'hc30e);
      access(1'b1, ADDR_HOST_CTRL, 16'h0102);
      settle();
      chk({fault_indicator_off, power_indicator_off, cmd_filter_on, smooth_drive_on}, 4'h1);
      chk(16'(n_rst - r0), 16'h0002);
      access(1'b1, ADDR_DRV_CFG, 16'h0000);
      cmd(1'b1);
      chk({user_cmd_err, cmd_exec_alarm, operating}, 3'b110);
      access(1'b1, ADDR_DRV_CFG, 16'h7848);
      access(1'b1, ADDR_STEP_RES, 16'h0014);
      access(1'b1, ADDR_MOTOR_SIZE, 16'hfa05);
      access(1'b1, ADDR_RUN_RATIO, 16'h03e8);
      access(1'b1, ADDR_HOST_CTRL, 16'h0106);
      settle();
      chk(cmd_exec_alarm, 1'b0);
      chk(step_resolution, RST_STEP_RES);
      chk(two_pulse_mode, 1'b0);
      cmd(1'b1);
      chk({user_cmd_err, operating, excite_on, two_pulse_mode}, 4'h7);
      chk(step_resolution, 16'h0014);
      chk(run_current_ma, 12'd2400);
      chk(hold_current_ma, scale(16'd2400, 16'h00fa));
      access(1'b1, ADDR_STEP_RES, 16'h0008);
      access(1'b1, ADDR_HOLD_RATIO, 16'h01f4);
      settle();
      chk(hold_current_ma, 12'd1200);
      chk(step_resolution, 16'h0014);
      rchk(ADDR_STEP_RES, 16'h0014);
      cmd(1'b1);
      chk({user_cmd_err, operating}, 2'b01);
      chk(step_resolution, 16'h0014);
      cmd(1'b0);
      chk({operating, excite_on}, 2'b00);
      close_out();
   end
endmodule
